// ==== design/ppc_params.svh ====
// Register indices, field positions and reset values of the port control registers
`ifndef PPC_PARAMS_SVH
`define PPC_PARAMS_SVH

// ==========================================================
// Register indices (byte address is four times the index)
`define PPC_IDX_P1_NEG_ADV 8'h1c
`define PPC_IDX_P1_LINE_B 8'h1d
`define PPC_IDX_P2_NEG_ADV 8'h2c
`define PPC_IDX_P2_LINE_B 8'h2d
`define PPC_IDX_P3_NEG_ADV 8'h3c
`define PPC_IDX_P3_LINE_B 8'h3d

// ==========================================================
// Negotiation and advertisement register fields
`define PPC_ADV_AN_EN 7
`define PPC_ADV_SPEED 6
`define PPC_ADV_DUPLEX 5
`define PPC_ADV_PAUSE 4
`define PPC_ADV_100FD 3
`define PPC_ADV_100HD 2
`define PPC_ADV_10FD 1
`define PPC_ADV_10HD 0

// ==========================================================
// Second line control register fields
`define PPC_LB_LED_OFF 7
`define PPC_LB_TX_DIS 6
`define PPC_LB_AN_RESTART 5
`define PPC_LB_FEF_DIS 4
`define PPC_LB_PWR_DOWN 3
`define PPC_LB_MDIX_OFF 2
`define PPC_LB_FORCE_MDI 1

// ==========================================================
// Reset values
`define PPC_NEG_ADV_RST 8'hff
`define PPC_LINE_B_RST 8'h00

`endif

// ==== design/ppc_pkg.sv ====
// Types shared by the port control register logic
package ppc_pkg;

   // ==========================================================
   // Control handed to one PHY core
   typedef struct packed {
      logic an_enable;
      logic speed_100;
      logic full_duplex;
      logic adv_pause;
      logic adv_100fd;
      logic adv_100hd;
      logic adv_10fd;
      logic adv_10hd;
      logic tx_disable;
      logic an_restart;
      logic fef_disable;
      logic power_down;
      logic mdix_auto_off;
      logic mdi_mode;
   } ppc_phy_ctl_s;

   // ==========================================================
   // State reported by one PHY core
   typedef struct packed {
      logic an_failed;
      logic an_full_duplex;
      logic an_speed_100;
      logic auto_mdi;
      logic led_one_raw;
      logic led_zero_raw;
   } ppc_phy_sts_s;

endpackage

// ==== design/ppc_port_ctrl.sv ====
// One port's negotiation and line control registers and their effect on the PHY
`timescale 1ns/1ps
`include "ppc_params.svh"
module ppc_port_ctrl
   import ppc_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic duplex_strap,
   input wire logic wr_neg_adv,
   input wire logic wr_line_b,
   input wire logic [7:0] wdata,
   input wire ppc_phy_sts_s phy_sts,
   output logic [7:0] neg_adv_q,
   output logic [7:0] line_b_q,
   output ppc_phy_ctl_s phy_ctl,
   output logic port_indicator_one,
   output logic port_indicator_zero
);

   logic strap_taken_r;
   logic [7:0] neg_adv_r;
   logic [7:0] line_b_r;
   logic an_in_charge;
   ppc_phy_ctl_s ctl_nxt;

   // ==========================================================
   // Strap capture after reset release
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         strap_taken_r <= 1'b0;
      end else begin
         strap_taken_r <= 1'b1;
      end
   end

   // ==========================================================
   // Negotiation and advertisement register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         neg_adv_r <= `PPC_NEG_ADV_RST;
      end else if (!strap_taken_r) begin
         neg_adv_r[`PPC_ADV_DUPLEX] <= duplex_strap;
      end else if (wr_neg_adv) begin
         neg_adv_r <= wdata;
      end
   end

   // ==========================================================
   // Second line control register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         line_b_r <= `PPC_LINE_B_RST;
      end else if (wr_line_b) begin
         line_b_r <= wdata;
      end
   end

   // Negotiated duplex applies only while negotiation is on and succeeded; negotiated speed applies whenever negotiation is on
   assign an_in_charge = neg_adv_r[`PPC_ADV_AN_EN] && !phy_sts.an_failed;

   always_comb begin
      ctl_nxt.an_enable = neg_adv_r[`PPC_ADV_AN_EN];
      ctl_nxt.speed_100 = neg_adv_r[`PPC_ADV_AN_EN] ? phy_sts.an_speed_100
                                                     : neg_adv_r[`PPC_ADV_SPEED];
      ctl_nxt.full_duplex = an_in_charge ? phy_sts.an_full_duplex
                                         : neg_adv_r[`PPC_ADV_DUPLEX];
      ctl_nxt.adv_pause = neg_adv_r[`PPC_ADV_PAUSE];
      ctl_nxt.adv_100fd = neg_adv_r[`PPC_ADV_100FD];
      ctl_nxt.adv_100hd = neg_adv_r[`PPC_ADV_100HD];
      ctl_nxt.adv_10fd = neg_adv_r[`PPC_ADV_10FD];
      ctl_nxt.adv_10hd = neg_adv_r[`PPC_ADV_10HD];
      ctl_nxt.tx_disable = line_b_r[`PPC_LB_TX_DIS];
      // Restart is a pulse per written one, so a stuck bit cannot loop negotiation
      ctl_nxt.an_restart = wr_line_b && wdata[`PPC_LB_AN_RESTART];
      ctl_nxt.fef_disable = line_b_r[`PPC_LB_FEF_DIS];
      ctl_nxt.power_down = line_b_r[`PPC_LB_PWR_DOWN];
      ctl_nxt.mdix_auto_off = line_b_r[`PPC_LB_MDIX_OFF];
      ctl_nxt.mdi_mode = line_b_r[`PPC_LB_MDIX_OFF] ? line_b_r[`PPC_LB_FORCE_MDI]
                                                    : phy_sts.auto_mdi;
   end

   // ==========================================================
   // Registered outputs to the PHY core and indicator pins
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         phy_ctl <= '0;
      end else begin
         phy_ctl <= ctl_nxt;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         port_indicator_one <= 1'b1;
         port_indicator_zero <= 1'b1;
      end else begin
         port_indicator_one <= line_b_r[`PPC_LB_LED_OFF] | phy_sts.led_one_raw;
         port_indicator_zero <= line_b_r[`PPC_LB_LED_OFF] | phy_sts.led_zero_raw;
      end
   end

   assign neg_adv_q = neg_adv_r;
   assign line_b_q = line_b_r;

endmodule // ppc_port_ctrl

// ==== design/ppc_regs.sv ====
// APB register bank for the copper port control registers of two PHY ports
//
// Chosen here: the APB interface to the registers.
`timescale 1ns/1ps
`include "ppc_params.svh"
module ppc_regs
   import ppc_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic first_port_duplex_strap,
   input wire logic second_port_duplex_strap,
   input wire ppc_phy_sts_s p1_sts,
   input wire ppc_phy_sts_s p2_sts,
   output ppc_phy_ctl_s p1_ctl,
   output ppc_phy_ctl_s p2_ctl,
   output logic p1_indicator_one,
   output logic p1_indicator_zero,
   output logic p2_indicator_one,
   output logic p2_indicator_zero
);

   typedef enum {
      PPC_SEL_P1_ADV,
      PPC_SEL_P1_LINE,
      PPC_SEL_P2_ADV,
      PPC_SEL_P2_LINE,
      PPC_SEL_RSVD,
      PPC_SEL_NONE
   } ppc_sel_e;

   logic [31:0] prdata_r;
   logic [7:0] p1_adv_q;
   logic [7:0] p1_line_q;
   logic [7:0] p2_adv_q;
   logic [7:0] p2_line_q;
   logic wr_ok;
   logic p1_wr_adv;
   logic p1_wr_line;
   logic p2_wr_adv;
   logic p2_wr_line;
   ppc_sel_e sel;

   // ==========================================================
   // Address decode
   function automatic logic [7:0] ppc_byte_addr(input logic [7:0] idx);
      ppc_byte_addr = {idx[5:0], 2'b00};
   endfunction

   function automatic ppc_sel_e ppc_decode(input logic [7:0] addr);
      if (addr == ppc_byte_addr(`PPC_IDX_P1_NEG_ADV)) begin
         ppc_decode = PPC_SEL_P1_ADV;
      end else if (addr == ppc_byte_addr(`PPC_IDX_P1_LINE_B)) begin
         ppc_decode = PPC_SEL_P1_LINE;
      end else if (addr == ppc_byte_addr(`PPC_IDX_P2_NEG_ADV)) begin
         ppc_decode = PPC_SEL_P2_ADV;
      end else if (addr == ppc_byte_addr(`PPC_IDX_P2_LINE_B)) begin
         ppc_decode = PPC_SEL_P2_LINE;
      end else if (addr == ppc_byte_addr(`PPC_IDX_P3_NEG_ADV) ||
                   addr == ppc_byte_addr(`PPC_IDX_P3_LINE_B)) begin
         ppc_decode = PPC_SEL_RSVD;
      end else begin
         ppc_decode = PPC_SEL_NONE;
      end
   endfunction

   assign sel = ppc_decode(paddr);

   // Zero wait states; read data is latched in the setup cycle
   assign pready = 1'b1;
   assign pslverr = psel && penable && (sel == PPC_SEL_NONE);

   // Only lane 0 carries a register, so a write without it changes nothing
   assign wr_ok = psel && penable && pwrite && pstrb[0];
   assign p1_wr_adv = wr_ok && (sel == PPC_SEL_P1_ADV);
   assign p1_wr_line = wr_ok && (sel == PPC_SEL_P1_LINE);
   assign p2_wr_adv = wr_ok && (sel == PPC_SEL_P2_ADV);
   assign p2_wr_line = wr_ok && (sel == PPC_SEL_P2_LINE);

   // ==========================================================
   // Read data
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_r <= 32'h0000_0000;
      end else if (psel && !penable) begin
         unique case (sel)
            PPC_SEL_P1_ADV: prdata_r <= {24'h00_0000, p1_adv_q};
            PPC_SEL_P1_LINE: prdata_r <= {24'h00_0000, p1_line_q};
            PPC_SEL_P2_ADV: prdata_r <= {24'h00_0000, p2_adv_q};
            PPC_SEL_P2_LINE: prdata_r <= {24'h00_0000, p2_line_q};
            PPC_SEL_RSVD: prdata_r <= 32'h0000_0000;
            PPC_SEL_NONE: prdata_r <= 32'h0000_0000;
         endcase
      end
   end

   assign prdata = prdata_r;

   // ==========================================================
   // Per-port register copies
   ppc_port_ctrl u_port1 (
      .pclk(pclk),
      .presetn(presetn),
      .duplex_strap(first_port_duplex_strap),
      .wr_neg_adv(p1_wr_adv),
      .wr_line_b(p1_wr_line),
      .wdata(pwdata[7:0]),
      .phy_sts(p1_sts),
      .neg_adv_q(p1_adv_q),
      .line_b_q(p1_line_q),
      .phy_ctl(p1_ctl),
      .port_indicator_one(p1_indicator_one),
      .port_indicator_zero(p1_indicator_zero)
   );

   ppc_port_ctrl u_port2 (
      .pclk(pclk),
      .presetn(presetn),
      .duplex_strap(second_port_duplex_strap),
      .wr_neg_adv(p2_wr_adv),
      .wr_line_b(p2_wr_line),
      .wdata(pwdata[7:0]),
      .phy_sts(p2_sts),
      .neg_adv_q(p2_adv_q),
      .line_b_q(p2_line_q),
      .phy_ctl(p2_ctl),
      .port_indicator_one(p2_indicator_one),
      .port_indicator_zero(p2_indicator_zero)
   );

   // ==========================================================
   // Checks
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence line_wr_s(logic wr, logic bitv);
      wr && bitv;
   endsequence

   sequence p1_adv_wr_s;
      p1_wr_adv;
   endsequence

   forced_duplex_a: assert property (
      (!p1_adv_q[`PPC_ADV_AN_EN] || p1_sts.an_failed)
      |=> p1_ctl.full_duplex == $past(p1_adv_q[`PPC_ADV_DUPLEX]))
      else $error("Port 1 duplex not taken from forced bit");

   adv_pause_a: assert property (
      p1_adv_wr_s |=> ##1 p1_ctl.adv_pause == $past(pwdata[`PPC_ADV_PAUSE], 2))
      else $error("Pause advertisement does not follow write");

   adv_100fd_a: assert property (
      p2_wr_adv |=> ##1 p2_ctl.adv_100fd == $past(pwdata[`PPC_ADV_100FD], 2))
      else $error("100 full advertisement does not follow write");

   adv_100hd_a: assert property (
      presetn |=> p1_ctl.adv_100hd == $past(p1_adv_q[`PPC_ADV_100HD]))
      else $error("100 half advertisement mismatch");

   adv_10fd_a: assert property (
      presetn |=> p2_ctl.adv_10fd == $past(p2_adv_q[`PPC_ADV_10FD]))
      else $error("10 full advertisement mismatch");

   adv_10hd_a: assert property (
      presetn |=> p1_ctl.adv_10hd == $past(p1_adv_q[`PPC_ADV_10HD]))
      else $error("10 half advertisement mismatch");

   led_off_a: assert property (
      p1_line_q[`PPC_LB_LED_OFF] [*2] |-> p1_indicator_one && p1_indicator_zero)
      else $error("Port 1 indicators not high while off");

   led_normal_a: assert property (
      presetn && !p2_line_q[`PPC_LB_LED_OFF]
      |=> p2_indicator_one == $past(p2_sts.led_one_raw))
      else $error("Port 2 indicator not following core");

   tx_disable_a: assert property (
      line_wr_s(p1_wr_line, pwdata[`PPC_LB_TX_DIS]) |=> ##1 p1_ctl.tx_disable)
      else $error("Transmitter not disabled after write");

   an_restart_a: assert property (
      line_wr_s(p2_wr_line, pwdata[`PPC_LB_AN_RESTART]) |=> p2_ctl.an_restart ##1
      (p2_ctl.an_restart == $past(p2_wr_line && pwdata[`PPC_LB_AN_RESTART])))
      else $error("Restart pulse missing or stuck");

   fef_disable_a: assert property (
      presetn |=> p1_ctl.fef_disable == $past(p1_line_q[`PPC_LB_FEF_DIS]))
      else $error("Far-end fault disable mismatch");

   power_down_a: assert property (
      line_wr_s(p2_wr_line, !pwdata[`PPC_LB_PWR_DOWN]) |=> ##1 !p2_ctl.power_down)
      else $error("Port 2 stays powered down");

   mdix_off_a: assert property (
      presetn |=> p2_ctl.mdix_auto_off == $past(p2_line_q[`PPC_LB_MDIX_OFF]))
      else $error("Crossover disable mismatch");

   forced_mdi_a: assert property (
      p1_line_q[`PPC_LB_MDIX_OFF]
      |=> p1_ctl.mdi_mode == $past(p1_line_q[`PPC_LB_FORCE_MDI]))
      else $error("Forced MDI mode not applied");

   auto_mdi_a: assert property (
      presetn && !p1_line_q[`PPC_LB_MDIX_OFF]
      |=> p1_ctl.mdi_mode == $past(p1_sts.auto_mdi))
      else $error("Auto crossover result not passed on");

   rsvd_read_a: assert property (
      psel && !penable && (sel == PPC_SEL_RSVD) |=> prdata == 32'h0000_0000)
      else $error("Reserved register reads nonzero");

   forced_speed_a: assert property (
      !p2_adv_q[`PPC_ADV_AN_EN]
      |=> p2_ctl.speed_100 == $past(p2_adv_q[`PPC_ADV_SPEED]) && !p2_ctl.an_enable)
      else $error("Forced speed not applied");

   reset_vals_a: assert property (
      $rose(presetn) |-> p1_line_q == `PPC_LINE_B_RST && p2_line_q == `PPC_LINE_B_RST
      && p1_adv_q[4:0] == 5'h1f && p2_adv_q[4:0] == 5'h1f)
      else $error("Reset values wrong");

   unmapped_err_a: assert property (
      psel && penable && (sel == PPC_SEL_NONE) |-> pslverr && pready)
      else $error("Unmapped access not flagged");

endmodule // ppc_regs

// ==== verif/ppc_phy_model.sv ====
// Behavioural model of one PHY core and its remote link partner
`timescale 1ns/1ps
module ppc_phy_model
   import ppc_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire ppc_phy_ctl_s ctl,
   input wire logic fail_an,
   output ppc_phy_sts_s sts
);
   logic fd_r;
   logic spd_r;
   logic mdi_r;
   logic [1:0] led_r;

   // ====================
   // Negotiation result
   // On each restart the partner takes 100 if any 100 mode is advertised and full duplex if any full mode is; crossover flips
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fd_r <= 1'b0;
         spd_r <= 1'b0;
         mdi_r <= 1'b0;
      end else if (ctl.an_restart) begin
         fd_r <= ctl.adv_100fd | ctl.adv_10fd;
         spd_r <= ctl.adv_100fd | ctl.adv_100hd;
         mdi_r <= ~mdi_r;
      end
   end

   // ====================
   // Raw indicator levels
   // Bit 0 changes every cycle, bit 1 every second cycle, so a stale copy of bit 0 is never mistaken for a live one
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         led_r <= 2'h0;
      end else begin
         led_r <= led_r + 2'h1;
      end
   end

   assign sts = '{an_failed: fail_an, an_full_duplex: fd_r, an_speed_100: spd_r,
                  auto_mdi: mdi_r, led_one_raw: led_r[0], led_zero_raw: led_r[1]};
endmodule // ppc_phy_model

// ==== verif/tb_ppc_regs.sv ====
// Self-checking testbench for the port control register bank
`timescale 1ns/1ps
`include "ppc_params.svh"
`define CHK(nm, ex, gt) begin tests_run++; if ((gt) !== (ex)) begin bad_count++; $display("[ERR] %s exp %h got %h", nm, ex, gt); end end
module tb_ppc_regs
   import ppc_pkg::*;
();
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [3:0] pstrb;
   logic fail1, fail2;
   ppc_phy_sts_s p1_sts, p2_sts;
   ppc_phy_ctl_s p1_ctl, p2_ctl;
   logic p1_i1, p1_i0, p2_i1, p2_i0;
   logic [1:0] raw1_d, raw2_d;
   int bad_count, tests_run, restarts;
   logic [7:0] adv_tab [5] = '{8'h35, 8'h4a, 8'ha0, 8'hbf, 8'h80};
   logic [7:0] line_tab [8] = '{8'h80, 8'h40, 8'h10, 8'h08, 8'h04, 8'h06, 8'h01, 8'h00};
   logic [7:0] adv_now [2];
   logic [7:0] a_adv [2];
   logic [7:0] a_line [2];

   // ====================
   // Clock, design and far side
   initial pclk = 1'b0;
   always #5 pclk = ~pclk;

   ppc_regs DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .first_port_duplex_strap(1'b1),
      .second_port_duplex_strap(1'b0), .p1_sts(p1_sts), .p2_sts(p2_sts),
      .p1_ctl(p1_ctl), .p2_ctl(p2_ctl), .p1_indicator_one(p1_i1),
      .p1_indicator_zero(p1_i0), .p2_indicator_one(p2_i1), .p2_indicator_zero(p2_i0));
   ppc_phy_model phy1 (.pclk(pclk), .presetn(presetn), .ctl(p1_ctl), .fail_an(fail1),
      .sts(p1_sts));
   ppc_phy_model phy2 (.pclk(pclk), .presetn(presetn), .ctl(p2_ctl), .fail_an(fail2),
      .sts(p2_sts));

   always @(posedge pclk) begin
      raw1_d <= {p1_sts.led_one_raw, p1_sts.led_zero_raw};
      raw2_d <= {p2_sts.led_one_raw, p2_sts.led_zero_raw};
      if (p2_ctl.an_restart === 1'b1) begin
         restarts++;
      end
   end

   // ====================
   // Tasks
   task end_sim;
      $display("checks %0d mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   task xfer(input logic [7:0] a, input logic w, input logic [7:0] d, input logic [3:0] s,
             input logic [7:0] ex, input logic exerr);
      logic ok;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h0, d};
      pstrb <= s;
      @(posedge pclk);
      penable <= 1'b1;
      ok = 1'b0;
      for (int n = 0; n < 16 && !ok; n++) begin
         @(posedge pclk);
         ok = (pready === 1'b1);
      end
      if (!ok) begin
         bad_count++;
         $display("[ERR] pready exp 1 got 0");
         end_sim();
      end
      if (!w) `CHK("prdata", {24'h0, ex}, prdata)
      `CHK("pslverr", exerr, pslverr)
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   function automatic ppc_phy_ctl_s exp_ctl(input logic [7:0] a, input logic [7:0] l,
                                            input ppc_phy_sts_s s);
      ppc_phy_ctl_s e;
      e = '0;
      e.an_enable = a[7];
      e.speed_100 = a[7] ? s.an_speed_100 : a[6];
      e.full_duplex = (a[7] && !s.an_failed) ? s.an_full_duplex : a[5];
      {e.adv_pause, e.adv_100fd, e.adv_100hd, e.adv_10fd, e.adv_10hd} = a[4:0];
      e.tx_disable = l[6];
      e.fef_disable = l[4];
      e.power_down = l[3];
      e.mdix_auto_off = l[2];
      e.mdi_mode = l[2] ? l[1] : s.auto_mdi;
      return e;
   endfunction

   // Outputs settle one edge after the store; look a full edge later
   task chk_port(input int p, input logic [7:0] l);
      repeat (2) @(posedge pclk);
      #1;
      `CHK("ctl", exp_ctl(adv_now[p], l, p ? p2_sts : p1_sts), p ? p2_ctl : p1_ctl)
      `CHK("indicators", {l[7], l[7]} | (p ? raw2_d : raw1_d), p ? {p2_i1, p2_i0} : {p1_i1, p1_i0})
   endtask

   // ====================
   // Main sequence
   initial begin
      {psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
      {presetn, fail1, fail2, restarts, bad_count, tests_run} = '0;
      a_adv = '{`PPC_IDX_P1_NEG_ADV << 2, `PPC_IDX_P2_NEG_ADV << 2};
      a_line = '{`PPC_IDX_P1_LINE_B << 2, `PPC_IDX_P2_LINE_B << 2};
      adv_now = '{`PPC_NEG_ADV_RST, `PPC_NEG_ADV_RST & 8'hdf};
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      repeat (2) @(posedge pclk);
      for (int p = 0; p < 2; p++) begin
         xfer(a_adv[p], 1'b0, 8'h00, 4'h0, adv_now[p], 1'b0);
         xfer(a_line[p], 1'b0, 8'h00, 4'h0, `PPC_LINE_B_RST, 1'b0);
         chk_port(p, 8'h00);
      end
      xfer(`PPC_IDX_P3_NEG_ADV << 2, 1'b0, 8'h00, 4'h0, 8'h00, 1'b0);
      $display("test reset values done");
      for (int f = 0; f < 2; f++) begin
         for (int i = 0; i < 5; i++) begin
            fail1 <= f[0];
            adv_now[0] = adv_tab[i];
            xfer(a_adv[0], 1'b1, adv_tab[i], 4'h1, 8'h00, 1'b0);
            xfer(a_adv[0], 1'b0, 8'h00, 4'h0, adv_tab[i], 1'b0);
            chk_port(0, 8'h00);
         end
      end
      adv_now[1] = 8'h4a;
      xfer(a_adv[1], 1'b1, 8'h4a, 4'h1, 8'h00, 1'b0);
      xfer(a_adv[1], 1'b0, 8'h00, 4'h0, 8'h4a, 1'b0);
      chk_port(1, 8'h00);
      $display("test advertisement done");
      for (int p = 0; p < 2; p++) begin
         for (int i = 0; i < 8; i++) begin
            xfer(a_line[p], 1'b1, line_tab[i], 4'h1, 8'h00, 1'b0);
            xfer(a_line[p], 1'b0, 8'h00, 4'h0, line_tab[i], 1'b0);
            chk_port(p, line_tab[i]);
         end
      end
      $display("test line control done");
      xfer(a_line[1], 1'b1, 8'h20, 4'h1, 8'h00, 1'b0);
      xfer(a_line[1], 1'b1, 8'h20, 4'h1, 8'h00, 1'b0);
      xfer(a_line[1], 1'b0, 8'h00, 4'h0, 8'h20, 1'b0);
      chk_port(1, 8'h20);
      `CHK("restart pulses", 2, restarts)
      $display("test restart done");
      xfer(`PPC_IDX_P3_LINE_B << 2, 1'b1, 8'hff, 4'h1, 8'h00, 1'b0);
      xfer(`PPC_IDX_P3_LINE_B << 2, 1'b0, 8'h00, 4'h0, 8'h00, 1'b0);
      xfer(8'h00, 1'b0, 8'h00, 4'h0, 8'h00, 1'b1);
      xfer(8'h00, 1'b1, 8'hff, 4'h1, 8'h00, 1'b1);
      xfer(a_line[0], 1'b1, 8'hff, 4'h0, 8'h00, 1'b0);
      xfer(a_line[0], 1'b0, 8'h00, 4'h0, 8'h00, 1'b0);
      $display("test refusals done");
      @(posedge pclk);
      presetn <= 1'b0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      repeat (2) @(posedge pclk);
      xfer(a_line[1], 1'b0, 8'h00, 4'h0, `PPC_LINE_B_RST, 1'b0);
      xfer(a_adv[0], 1'b0, 8'h00, 4'h0, `PPC_NEG_ADV_RST, 1'b0);
      $display("test second reset done");
      end_sim();
   end
endmodule // tb_ppc_regs
